// file: rtl/bspc_hiccup.sv
// Hiccup supervisor: counts clamped switching cycles and the restart wait
`timescale 1ns/10ps
`default_nettype none
`include "bspc_cfg.svh"

module bspc_hiccup
  import bspc_pkg::*;
#(
  parameter int CLAMP_WAIT = `BSPC_CLAMP_WAIT,
  parameter int HICCUP_CYCLES = `BSPC_HICCUP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  bspc_hic_if.hic hic
);

  bspc_hic_type state_q;
  logic [15:0] clamp_cnt_q;
  logic [15:0] wait_cnt_q;
  logic enter_q;

  // Supervisor sequence; counts advance once per switching cycle, enable changes act on any clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= BSPC_HIC_OFF;
      clamp_cnt_q <= 16'h0000;
      wait_cnt_q <= 16'h0000;
      enter_q <= 1'b0;
    end else begin
      enter_q <= 1'b0;
      case (state_q)
        BSPC_HIC_OFF: begin
          clamp_cnt_q <= 16'h0000;
          wait_cnt_q <= 16'h0000;
          if (hic.enable) begin
            state_q <= BSPC_HIC_WATCH;
          end
        end
        BSPC_HIC_WATCH: begin
          if (!hic.enable) begin
            state_q <= BSPC_HIC_OFF;
          end else if (hic.cycle_tick) begin
            if (!hic.clamp) begin
              clamp_cnt_q <= 16'h0000;
            end else if (clamp_cnt_q >= 16'(CLAMP_WAIT)) begin
              state_q <= BSPC_HIC_WAIT;
              enter_q <= 1'b1;
              clamp_cnt_q <= 16'h0000;
              wait_cnt_q <= 16'h0000;
            end else begin
              clamp_cnt_q <= clamp_cnt_q + 16'h0001;
            end
          end
        end
        BSPC_HIC_WAIT: begin
          // Disable aborts the wait; a fresh enable starts clean
          if (!hic.enable) begin
            state_q <= BSPC_HIC_OFF;
          end else if (hic.cycle_tick) begin
            if (wait_cnt_q >= 16'(HICCUP_CYCLES - 1)) begin
              state_q <= BSPC_HIC_WATCH;
              wait_cnt_q <= 16'h0000;
            end else begin
              wait_cnt_q <= wait_cnt_q + 16'h0001;
            end
          end
        end
        default: begin
          state_q <= BSPC_HIC_OFF;
        end
      endcase
    end
  end

  assign hic.hiccup_active = (state_q == BSPC_HIC_WAIT);
  assign hic.hiccup_enter = enter_q;

endmodule : bspc_hiccup

`default_nettype wire

// file: rtl/bspc_sync.sv
// Two-flop synchroniser bank for the asynchronous comparator flags
`timescale 1ns/10ps
`default_nettype none

module bspc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // One independent two-stage chain per flag; bits are not coherent with each other
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= async_in[gi];
          sync_q <= meta_q;
        end
      end
      assign sync_out[gi] = sync_q;
    end
  endgenerate

endmodule : bspc_sync

`default_nettype wire

// file: rtl/bspc_top.sv
// Buck switch protection controller: per-cycle gate control, protection and registers
//
// Contract
// - With bootstrap healthy, high-side may stay on continuously across switching cycles.
// - Peak trips closer than 100 ns before cycle end are ignored.
// - Bootstrap undervoltage turns high-side off and low-side on for recharge.
// - Any low-side on interval counts as bootstrap recharge; no extra action.
// - Feedback above 108% level forces the high-side off.
// - Overvoltage turn-off of high-side turns the low-side on.
// - After overvoltage, high-side returns at next cycle once below 106%.
// - Peak current reaching reference turns high-side off, low-side on.
// - Clamp held over 512 switching cycles shuts down into hiccup.
// - Hiccup holds both switches off 16384 cycles, then restarts.
// - Source over-limit at cycle end skips next high-side, keeps low-side.
// - High-side resumes only when cycle start sees source current below limit.
// - Sink over-limit turns low-side off at once, both off until next cycle.
// - Low-side returns only after high-side on then off, or bootstrap undervoltage.
// - Active only when input above 4.1 V and enable above 1.20 V.
// - Enable low holds both switches off in shutdown.
`timescale 1ns/10ps
`default_nettype none
`include "bspc_cfg.svh"

module bspc_top
  import bspc_pkg::*;
#(
  parameter int CLAMP_WAIT = `BSPC_CLAMP_WAIT,
  parameter int HICCUP_CYCLES = `BSPC_HICCUP_CYCLES,
  parameter int MIN_OFF_CYC = `BSPC_MIN_OFF_CYC,
  parameter int DEAD_CYC = `BSPC_DEAD_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic BOOTSTRAP_UNDERVOLTAGE_FLAG_IN,
  input wire logic FEEDBACK_SENSE_OVER_IN,
  input wire logic FEEDBACK_SENSE_RECOVER_IN,
  input wire logic PEAK_TRIP_IN,
  input wire logic COMP_CLAMP_IN,
  input wire logic LS_SOURCE_OVER_IN,
  input wire logic LS_SINK_OVER_IN,
  input wire logic INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN,
  input wire logic ENABLE_OK_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WR_DATA_IN,
  input wire logic WR_STB_IN,
  input wire logic RD_STB_IN,
  output logic [31:0] RD_DATA_OUT,
  output logic HS_GATE_OUT,
  output logic LS_GATE_OUT,
  output logic IRQ_OUT
);

  localparam int NFLAG = 9;

  // Synchronised comparator flags
  logic [NFLAG-1:0] flags_s;
  logic boot_uv;
  logic fb_over;
  logic fb_recover;
  logic peak_trip;
  logic comp_clamp;
  logic src_over;
  logic sink_over;
  logic vin_ok;
  logic en_ok;

  // Registers and controller state
  logic [31:0] ctrl_q;
  logic [`BSPC_EV_WIDTH-1:0] status_q;
  logic [`BSPC_EV_WIDTH-1:0] mask_q;
  logic [15:0] period_q;
  logic [15:0] cyc_cnt_q;
  logic cycle_tick;
  logic active;
  logic overvolt_q;
  logic hs_phase_q;
  logic sink_off_q;
  logic ls_lock_q;
  logic boot_uv_prev_q;
  logic fb_over_prev_q;
  logic [`BSPC_EV_WIDTH-1:0] events;
  bspc_gate_type want;
  bspc_gate_type gate_q;
  logic [7:0] dead_cnt_q;
  logic hs_gate_q;
  logic ls_gate_q;
  logic irq_q;
  logic [31:0] rd_data_q;
  logic [31:0] state_word;
  logic near_end;
  logic peak_cut;

  bspc_hic_if hic_bus ();

  // Every comparator flag is asynchronous to the controller clock
  bspc_sync #(
    .WIDTH(NFLAG)
  ) u_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .async_in({ENABLE_OK_IN, INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN, LS_SINK_OVER_IN,
               LS_SOURCE_OVER_IN, COMP_CLAMP_IN, PEAK_TRIP_IN,
               FEEDBACK_SENSE_RECOVER_IN, FEEDBACK_SENSE_OVER_IN,
               BOOTSTRAP_UNDERVOLTAGE_FLAG_IN}),
    .sync_out(flags_s)
  );

  assign boot_uv = flags_s[0];
  assign fb_over = flags_s[1];
  assign fb_recover = flags_s[2];
  assign peak_trip = flags_s[3];
  assign comp_clamp = flags_s[4];
  assign src_over = flags_s[5];
  assign sink_over = flags_s[6];
  assign vin_ok = flags_s[7];
  assign en_ok = flags_s[8];

  // Hiccup supervisor watches the clamp only while the converter may run
  assign hic_bus.cycle_tick = cycle_tick;
  assign hic_bus.clamp = comp_clamp;
  assign hic_bus.enable = vin_ok & en_ok & ctrl_q[`BSPC_CTRL_RUN_BIT];

  bspc_hiccup #(
    .CLAMP_WAIT(CLAMP_WAIT),
    .HICCUP_CYCLES(HICCUP_CYCLES)
  ) u_hiccup (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .hic(hic_bus.hic)
  );

  // Both flags and the run bit must agree, and hiccup blanks everything
  assign active = hic_bus.enable & ~hic_bus.hiccup_active;

  // Switching-cycle divider; the tick marks both cycle end and next start
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cyc_cnt_q <= 16'h0000;
    end else if (cycle_tick) begin
      cyc_cnt_q <= 16'h0000;
    end else begin
      cyc_cnt_q <= cyc_cnt_q + 16'h0001;
    end
  end

  assign cycle_tick = (cyc_cnt_q >= period_q - 16'h0001);
  // A trip this late would leave an off time shorter than the minimum
  assign near_end = ({1'b0, cyc_cnt_q} + 17'(MIN_OFF_CYC)) >= {1'b0, period_q};
  assign peak_cut = peak_trip & ~near_end;

  // Overvoltage latch with hysteresis; release only on a cycle boundary
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      overvolt_q <= 1'b0;
    end else if (fb_over) begin
      overvolt_q <= 1'b1;
    end else if (cycle_tick && fb_recover) begin
      overvolt_q <= 1'b0;
    end
  end

  // High-side phase: armed at cycle start, cut by peak, overvoltage or bootstrap
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hs_phase_q <= 1'b0;
    end else if (!active || fb_over || boot_uv) begin
      hs_phase_q <= 1'b0;
    end else if (cycle_tick) begin
      // Re-arming an unbroken phase keeps the switch on through the boundary
      hs_phase_q <= ~src_over & ~(overvolt_q & ~fb_recover);
    end else if (peak_cut) begin
      hs_phase_q <= 1'b0;
    end
  end

  // Sink limit: both off for the rest of the cycle
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sink_off_q <= 1'b0;
    end else if (sink_over && gate_q == BSPC_GATE_LS) begin
      sink_off_q <= 1'b1;
    end else if (cycle_tick) begin
      sink_off_q <= 1'b0;
    end
  end

  // Low-side lock after a sink trip, freed by a full high-side pulse or bootstrap need
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ls_lock_q <= 1'b0;
    end else if (sink_over && gate_q == BSPC_GATE_LS) begin
      ls_lock_q <= 1'b1;
    end else if (boot_uv || (hs_gate_q && want != BSPC_GATE_HS)) begin
      ls_lock_q <= 1'b0;
    end
  end

  // Requested switch; any low-side interval doubles as bootstrap recharge
  always_comb begin
    want = BSPC_GATE_NONE;
    if (!active) begin
      want = BSPC_GATE_NONE;
    end else if (hs_phase_q && !boot_uv && !overvolt_q && !fb_over) begin
      want = BSPC_GATE_HS;
    end else if (boot_uv) begin
      want = BSPC_GATE_LS;
    end else if (sink_off_q || ls_lock_q || sink_over) begin
      want = BSPC_GATE_NONE;
    end else begin
      want = BSPC_GATE_LS;
    end
  end

  // Gate stage: a change always passes through a dead interval with both off
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gate_q <= BSPC_GATE_NONE;
      dead_cnt_q <= 8'h00;
    end else begin
      case (gate_q)
        BSPC_GATE_HS, BSPC_GATE_LS: begin
          if (want != gate_q) begin
            gate_q <= BSPC_GATE_NONE;
            dead_cnt_q <= 8'(DEAD_CYC);
          end
        end
        BSPC_GATE_NONE: begin
          if (dead_cnt_q != 8'h00) begin
            dead_cnt_q <= dead_cnt_q - 8'h01;
          end else if (want != BSPC_GATE_NONE) begin
            gate_q <= want;
          end
        end
        default: begin
          gate_q <= BSPC_GATE_NONE;
        end
      endcase
    end
  end

  // Output flops follow the gate stage; sink trip drops low-side without delay
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hs_gate_q <= 1'b0;
      ls_gate_q <= 1'b0;
    end else begin
      hs_gate_q <= (gate_q == BSPC_GATE_HS) && (want == BSPC_GATE_HS);
      ls_gate_q <= (gate_q == BSPC_GATE_LS) && (want == BSPC_GATE_LS);
    end
  end

  // Edge history for event detection on level flags
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      boot_uv_prev_q <= 1'b0;
      fb_over_prev_q <= 1'b0;
    end else begin
      boot_uv_prev_q <= boot_uv;
      fb_over_prev_q <= fb_over;
    end
  end

  always_comb begin
    events = '0;
    events[`BSPC_EV_OVERVOLT] = fb_over & ~fb_over_prev_q;
    events[`BSPC_EV_PEAK] = peak_cut & hs_phase_q & ~cycle_tick;
    events[`BSPC_EV_SOURCE] = cycle_tick & src_over & active;
    events[`BSPC_EV_SINK] = sink_over & (gate_q == BSPC_GATE_LS);
    events[`BSPC_EV_BOOT_UV] = boot_uv & ~boot_uv_prev_q;
    events[`BSPC_EV_HICCUP] = hic_bus.hiccup_enter;
  end

  // Register writes
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_q <= `BSPC_CTRL_RESET;
      mask_q <= `BSPC_MASK_RESET;
      period_q <= `BSPC_PERIOD_RESET;
    end else if (WR_STB_IN) begin
      case (ADDR_IN)
        `BSPC_OFS_CTRL: ctrl_q <= {31'h0000_0000, WR_DATA_IN[`BSPC_CTRL_RUN_BIT]};
        `BSPC_OFS_MASK: mask_q <= WR_DATA_IN[`BSPC_EV_WIDTH-1:0];
        // A period below two clocks would stall the divider compare
        `BSPC_OFS_PERIOD: period_q <= (WR_DATA_IN[15:0] < 16'h0002) ? 16'h0002 : WR_DATA_IN[15:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status; a new event in the clearing read's cycle survives
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      status_q <= '0;
    end else if (RD_STB_IN && ADDR_IN == `BSPC_OFS_STATUS) begin
      status_q <= events;
    end else begin
      status_q <= status_q | events;
    end
  end

  assign state_word = {24'h00_0000, ls_lock_q, overvolt_q, active, hic_bus.hiccup_active,
                       ls_gate_q, hs_gate_q, gate_q};

  // Read data is valid in the cycle after the strobe only
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_data_q <= 32'h0000_0000;
    end else if (RD_STB_IN) begin
      case (ADDR_IN)
        `BSPC_OFS_CTRL: rd_data_q <= ctrl_q;
        `BSPC_OFS_STATUS: rd_data_q <= {26'h000_0000, status_q};
        `BSPC_OFS_MASK: rd_data_q <= {26'h000_0000, mask_q};
        `BSPC_OFS_STATE: rd_data_q <= state_word;
        `BSPC_OFS_PERIOD: rd_data_q <= {16'h0000, period_q};
        default: rd_data_q <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  // Level interrupt from any unmasked sticky bit
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign RD_DATA_OUT = rd_data_q;
  assign HS_GATE_OUT = hs_gate_q;
  assign LS_GATE_OUT = ls_gate_q;
  assign IRQ_OUT = irq_q;

endmodule : bspc_top

`default_nettype wire

// file: shared/bspc_cfg.svh
// Constants for the buck switch protection controller: offsets, fields, resets, timing
`ifndef BSPC_CFG_SVH
`define BSPC_CFG_SVH

// Register byte offsets
`define BSPC_OFS_CTRL 8'h00
`define BSPC_OFS_STATUS 8'h04
`define BSPC_OFS_MASK 8'h08
`define BSPC_OFS_STATE 8'h0C
`define BSPC_OFS_PERIOD 8'h10

// Control register fields
`define BSPC_CTRL_RUN_BIT 0
`define BSPC_CTRL_RESET 32'h0000_0001

// Status and mask bit positions
`define BSPC_EV_OVERVOLT 0
`define BSPC_EV_PEAK 1
`define BSPC_EV_SOURCE 2
`define BSPC_EV_SINK 3
`define BSPC_EV_BOOT_UV 4
`define BSPC_EV_HICCUP 5
`define BSPC_EV_WIDTH 6
`define BSPC_MASK_RESET 6'h00

// State register fields
`define BSPC_ST_GATE_LSB 0
`define BSPC_ST_HS_BIT 2
`define BSPC_ST_LS_BIT 3
`define BSPC_ST_HICCUP_BIT 4
`define BSPC_ST_ACTIVE_BIT 5
`define BSPC_ST_OVERVOLT_BIT 6
`define BSPC_ST_LS_LOCK_BIT 7

// Switching period in clocks, about 700 kHz at 100 MHz
`define BSPC_PERIOD_RESET 16'h008F

// Timing figures
`define BSPC_CLK_MHZ 100
`define BSPC_MIN_OFF_NS 100
`define BSPC_DEAD_NS 20
`define BSPC_MIN_OFF_CYC ((`BSPC_MIN_OFF_NS * `BSPC_CLK_MHZ + 999) / 1000)
`define BSPC_DEAD_CYC ((`BSPC_DEAD_NS * `BSPC_CLK_MHZ + 999) / 1000)

// Hiccup counts in switching cycles
`define BSPC_CLAMP_WAIT 512
`define BSPC_HICCUP_CYCLES 16384

`endif

// file: shared/bspc_hic_if.sv
// Interface between the gate controller and the hiccup supervisor
`timescale 1ns/10ps
`default_nettype none

interface bspc_hic_if;
  logic cycle_tick;
  logic clamp;
  logic enable;
  logic hiccup_active;
  logic hiccup_enter;

  modport ctrl (
    output cycle_tick,
    output clamp,
    output enable,
    input hiccup_active,
    input hiccup_enter
  );

  modport hic (
    input cycle_tick,
    input clamp,
    input enable,
    output hiccup_active,
    output hiccup_enter
  );
endinterface : bspc_hic_if

`default_nettype wire

// file: shared/bspc_pkg.sv
// Types shared by the buck switch protection controller modules
package bspc_pkg;

  // Which power switch the gate stage drives
  typedef enum logic [1:0] {
    BSPC_GATE_NONE = 2'b00,
    BSPC_GATE_HS = 2'b01,
    BSPC_GATE_LS = 2'b10
  } bspc_gate_type;

  // Hiccup supervisor states
  typedef enum logic [1:0] {
    BSPC_HIC_OFF = 2'b00,
    BSPC_HIC_WATCH = 2'b01,
    BSPC_HIC_WAIT = 2'b10
  } bspc_hic_type;

endpackage : bspc_pkg

// file: tb/bspc_stage_model.sv
// Behavioural power stage: inductor current ramp and bootstrap charge
`timescale 1ns/10ps
`default_nettype none

module bspc_stage_model #(
  parameter int PEAK_AT = 12,
  parameter int BOOT_HOLD = 150
) (
  input wire logic clk_in,
  input wire logic hs_in,
  input wire logic ls_in,
  input wire logic peak_en_in,
  output logic peak_trip_out,
  output logic boot_uv_out
);
  int unsigned on_cnt = 0;
  int unsigned drain_cnt = 0;
  logic peak_q = 1'b0;
  logic uv_q = 1'b0;

  // Current ramps while the high side conducts; peak_en off models dropout
  always @(posedge clk_in) begin
    on_cnt <= hs_in ? on_cnt + 1 : 0;
    peak_q <= peak_en_in && hs_in && (on_cnt >= PEAK_AT);
  end

  // Gate drive drains the cap slowly; any low-side interval refills it
  always @(posedge clk_in) begin
    if (ls_in) begin
      drain_cnt <= 0;
    end else if (hs_in) begin
      drain_cnt <= drain_cnt + 1;
    end
    uv_q <= (drain_cnt >= BOOT_HOLD);
  end

  assign peak_trip_out = peak_q;
  assign boot_uv_out = uv_q;
endmodule : bspc_stage_model

`default_nettype wire

// file: tb/bspc_top_sva.sv
// Checker for gate safety and protection responses of the switch controller
`timescale 1ns/10ps
`default_nettype none

module bspc_top_chk (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic BOOTSTRAP_UNDERVOLTAGE_FLAG_IN,
  input wire logic FEEDBACK_SENSE_OVER_IN,
  input wire logic LS_SINK_OVER_IN,
  input wire logic COMP_CLAMP_IN,
  input wire logic INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN,
  input wire logic ENABLE_OK_IN,
  input wire logic HS_GATE_OUT,
  input wire logic LS_GATE_OUT,
  input wire logic IRQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // Overvoltage held with nothing else competing for the low side
  sequence ovp_held;
    (FEEDBACK_SENSE_OVER_IN && ENABLE_OK_IN && INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN &&
     !LS_SINK_OVER_IN && !COMP_CLAMP_IN) [*8];
  endsequence

  // Shoot-through would short the input rail
  chk_no_overlap: assert property (!(HS_GATE_OUT && LS_GATE_OUT))
    else $error("both gates on");
  chk_hs_dead_gap: assert property ($fell(HS_GATE_OUT) |-> !LS_GATE_OUT [*3])
    else $error("low side too soon after high side");
  chk_ls_dead_gap: assert property ($fell(LS_GATE_OUT) |-> !HS_GATE_OUT [*3])
    else $error("high side too soon after low side");
  // Flags pass a synchroniser, so allow eight clocks of lag
  chk_enable_off: assert property ((!ENABLE_OK_IN) [*8] |-> !HS_GATE_OUT && !LS_GATE_OUT)
    else $error("gate on while disabled");
  chk_vin_low_off: assert property ((!INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN) [*8] |->
    !HS_GATE_OUT && !LS_GATE_OUT)
    else $error("gate on with input low");
  chk_ovp_hs_off: assert property (FEEDBACK_SENSE_OVER_IN [*8] |-> !HS_GATE_OUT)
    else $error("high side on during overvoltage");
  chk_ovp_ls_on: assert property (ovp_held ##1 ovp_held |-> LS_GATE_OUT)
    else $error("low side not discharging during overvoltage");
  chk_sink_ls_off: assert property ((LS_SINK_OVER_IN && !BOOTSTRAP_UNDERVOLTAGE_FLAG_IN) [*8]
    |-> !LS_GATE_OUT)
    else $error("low side on past sink limit");

  cov_hs_on: cover property ($rose(HS_GATE_OUT));
  cov_irq: cover property ($rose(IRQ_OUT));
  cov_clamp_off: cover property (COMP_CLAMP_IN [*8] ##1 !HS_GATE_OUT);
endmodule : bspc_top_chk

bind bspc_top bspc_top_chk u_chk (
  .CLK_IN(CLK_IN),
  .RST_N_IN(RST_N_IN),
  .BOOTSTRAP_UNDERVOLTAGE_FLAG_IN(BOOTSTRAP_UNDERVOLTAGE_FLAG_IN),
  .FEEDBACK_SENSE_OVER_IN(FEEDBACK_SENSE_OVER_IN),
  .LS_SINK_OVER_IN(LS_SINK_OVER_IN),
  .COMP_CLAMP_IN(COMP_CLAMP_IN),
  .INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN(INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN),
  .ENABLE_OK_IN(ENABLE_OK_IN),
  .HS_GATE_OUT(HS_GATE_OUT),
  .LS_GATE_OUT(LS_GATE_OUT),
  .IRQ_OUT(IRQ_OUT)
);

`default_nettype wire

// file: tb/bspc_top_tb.sv
// Self-checking bench for the buck switch protection controller
`timescale 1ns/10ps
`default_nettype none
`include "bspc_cfg.svh"

module bspc_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic over = 1'b0, recover = 1'b1, clamp = 1'b0, src = 1'b0, sink = 1'b0;
  logic vin = 1'b0, en = 1'b0, wr = 1'b0, rd = 1'b0, peak_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic boot_uv, peak, hs, ls, irq;
  int n_mismatch = 0, checked = 0;

  // Short hiccup counts keep the run brief
  bspc_top #(.CLAMP_WAIT(4), .HICCUP_CYCLES(8)) dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .BOOTSTRAP_UNDERVOLTAGE_FLAG_IN(boot_uv),
    .FEEDBACK_SENSE_OVER_IN(over), .FEEDBACK_SENSE_RECOVER_IN(recover),
    .PEAK_TRIP_IN(peak), .COMP_CLAMP_IN(clamp), .LS_SOURCE_OVER_IN(src),
    .LS_SINK_OVER_IN(sink), .INPUT_UNDERVOLTAGE_LOCKOUT_OK_IN(vin), .ENABLE_OK_IN(en),
    .ADDR_IN(addr), .WR_DATA_IN(wdata), .WR_STB_IN(wr), .RD_STB_IN(rd),
    .RD_DATA_OUT(rdata), .HS_GATE_OUT(hs), .LS_GATE_OUT(ls), .IRQ_OUT(irq));

  bspc_stage_model #(.PEAK_AT(12), .BOOT_HOLD(150)) stage (
    .clk_in(clk), .hs_in(hs), .ls_in(ls), .peak_en_in(peak_en),
    .peak_trip_out(peak), .boot_uv_out(boot_uv));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t word got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmpb(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : cmpb

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    cmp(v, exp);
  endtask : rd_chk

  // Bounded wait for a gate pattern, then compare it
  task automatic waitg(input logic h, input logic l, input int lim);
    int i;
    i = 0;
    @(negedge clk);
    while ((hs !== h || ls !== l) && i < lim) begin
      @(negedge clk);
      i++;
    end
    cmpb(hs, h);
    cmpb(ls, l);
  endtask : waitg

  task automatic hold_hs(input logic h, input int n);
    repeat (n) begin
      @(negedge clk);
      cmpb(hs, h);
    end
  endtask : hold_hs

  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Sequence needs about 2000 clocks; twenty thousand cuts a hang
  initial begin
    #200000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, an unmapped hole, and the period floor
    rd_chk(`BSPC_OFS_CTRL, 32'h1);
    rd_chk(`BSPC_OFS_MASK, 32'h0);
    rd_chk(`BSPC_OFS_PERIOD, 32'h8F);
    rd_chk(`BSPC_OFS_STATUS, 32'h0);
    rd_chk(8'h14, 32'h0);
    wr_reg(`BSPC_OFS_PERIOD, 32'h1);
    rd_chk(`BSPC_OFS_PERIOD, 32'h2);
    wr_reg(`BSPC_OFS_PERIOD, 32'h28);
    wr_reg(`BSPC_OFS_MASK, 32'h1);
    hold_hs(1'b0, 100);
    @(posedge clk) en <= 1'b1;
    hold_hs(1'b0, 100);
    @(posedge clk) vin <= 1'b1;
    waitg(1'b1, 1'b0, 100);
    waitg(1'b0, 1'b1, 40);
    rd_chk(`BSPC_OFS_STATUS, 32'h2);
    cmpb(irq, 1'b0);
    // Dropout: high side stays on across ticks until the cap runs low
    @(posedge clk) peak_en <= 1'b0;
    waitg(1'b1, 1'b0, 60);
    hold_hs(1'b1, 100);
    waitg(1'b0, 1'b1, 100);
    rd_reg(`BSPC_OFS_STATUS, d);
    cmpb(d[`BSPC_EV_BOOT_UV], 1'b1);
    @(posedge clk) peak_en <= 1'b1;
    // Overvoltage, then the hysteresis band, then recovery
    @(posedge clk) recover <= 1'b0;
    over <= 1'b1;
    waitg(1'b0, 1'b1, 20);
    hold_hs(1'b0, 60);
    waitg(1'b0, 1'b1, 1);
    cmpb(irq, 1'b1);
    @(posedge clk) over <= 1'b0;
    hold_hs(1'b0, 80);
    @(posedge clk) recover <= 1'b1;
    waitg(1'b1, 1'b0, 60);
    rd_reg(`BSPC_OFS_STATUS, d);
    cmpb(d[`BSPC_EV_OVERVOLT], 1'b1);
    repeat (3) @(negedge clk);
    cmpb(irq, 1'b0);
    // Low-side sourcing limit skips high-side cycles
    @(posedge clk) src <= 1'b1;
    repeat (45) @(posedge clk);
    hold_hs(1'b0, 100);
    cmpb(ls, 1'b1);
    @(posedge clk) src <= 1'b0;
    waitg(1'b1, 1'b0, 60);
    // Sinking limit drops the low side until a new high-side pulse
    waitg(1'b0, 1'b1, 60);
    @(posedge clk) sink <= 1'b1;
    waitg(1'b0, 1'b0, 10);
    repeat (20) @(posedge clk);
    @(posedge clk) sink <= 1'b0;
    waitg(1'b1, 1'b0, 60);
    waitg(1'b0, 1'b1, 40);
    // Short clamp bursts must not accumulate; a long one trips hiccup
    rd_reg(`BSPC_OFS_STATUS, d);
    @(posedge clk) clamp <= 1'b1;
    repeat (150) @(posedge clk);
    @(posedge clk) clamp <= 1'b0;
    repeat (50) @(posedge clk);
    @(posedge clk) clamp <= 1'b1;
    repeat (150) @(posedge clk);
    rd_reg(`BSPC_OFS_STATUS, d);
    cmpb(d[`BSPC_EV_HICCUP], 1'b0);
    repeat (110) @(posedge clk);
    waitg(1'b0, 1'b0, 1);
    hold_hs(1'b0, 200);
    cmpb(ls, 1'b0);
    rd_reg(`BSPC_OFS_STATUS, d);
    cmpb(d[`BSPC_EV_HICCUP], 1'b1);
    rd_chk(`BSPC_OFS_STATE, 32'h0000_0001 << `BSPC_ST_HICCUP_BIT);
    @(posedge clk) clamp <= 1'b0;
    waitg(1'b1, 1'b0, 400);
    // Clearing the run bit stops switching; setting it again restarts
    wr_reg(`BSPC_OFS_CTRL, 32'h0);
    waitg(1'b0, 1'b0, 10);
    rd_chk(`BSPC_OFS_CTRL, 32'h0);
    wr_reg(`BSPC_OFS_CTRL, 32'h1);
    waitg(1'b1, 1'b0, 100);
    // Enable dropped mid-run
    @(posedge clk) en <= 1'b0;
    waitg(1'b0, 1'b0, 10);
    hold_hs(1'b0, 60);
    end_of_test;
  end
endmodule : bspc_top_tb

`default_nettype wire
